/* File: shared/hrs_consts.svh */
// constants for the host-bus response and special-cycle block
`ifndef HRS_CONSTS_SVH
`define HRS_CONSTS_SVH
`define HRS_RS_IDLE      3'h0
`define HRS_RS_RETRY     3'h1
`define HRS_RS_DEFER     3'h2
`define HRS_RS_NODATA    3'h5
`define HRS_RS_IWB       3'h6
`define HRS_RS_NORMAL    3'h7
`define HRS_REQA_SPECIAL 5'h08
`define HRS_REQB_SPECIAL 3'h1
`define HRS_SC_NOP       8'h00
`define HRS_SC_SHUTDOWN  8'h01
`define HRS_SC_FLUSH     8'h02
`define HRS_SC_HALT      8'h03
`define HRS_SC_SYNC      8'h04
`define HRS_SC_FLUSH_ACK 8'h05
`define HRS_SC_STOP_ACK  8'h06
`define HRS_SC_SMM_ACK   8'h07
`define HRS_IOQ_DEPTH    4
`endif

/* File: shared/hrs_pkg.sv */
// types for the host-bus response and special-cycle block
package hrs_pkg;
   // hub-side special cycle kinds
   typedef enum logic [1:0] {
      HRS_HUB_SHUTDOWN = 2'h0,
      HRS_HUB_HALT     = 2'h1,
      HRS_HUB_STOP     = 2'h2
   } hrs_hub_kind_e;
   // response state
   typedef enum logic [1:0] {
      HRS_IDLE = 2'h0,
      HRS_HUB  = 2'h1,
      HRS_RESP = 2'h3
   } hrs_state_e;
endpackage : hrs_pkg

/* File: rtl/hrs_ioq.sv */
// in-order queue of pending host requests
`timescale 1ns/1ns
`default_nettype none
module hrs_ioq #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             ref_clk,  // host clock
   input  wire logic             resetn,   // async reset, low
   input  wire logic             push,     // new request
   input  wire logic [WIDTH-1:0] push_data,// request word
   input  wire logic             pop,      // retire head
   output logic                  full,     // no free slot
   output logic                  empty,    // nothing pending
   output logic      [WIDTH-1:0] head      // oldest request
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp, rp, next_wp, next_rp;
   logic [AW:0]      cnt, next_cnt;
   logic             do_push, do_pop;

   // pointer and count update
   always_comb begin
      do_push  = push && !full;
      do_pop   = pop && !empty;
      next_wp  = do_push ? AW'(wp + 1'b1) : wp;
      next_rp  = do_pop ? AW'(rp + 1'b1) : rp;
      next_cnt = (AW+1)'(cnt + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop});
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         wp  <= next_wp;
         rp  <= next_rp;
         cnt <= next_cnt;
      end
   end

   // storage, no reset needed
   always_ff @(posedge ref_clk) begin
      if (do_push) begin
         mem[wp] <= push_data;
      end
   end

   assign full  = (cnt == (AW+1)'(DEPTH));
   assign empty = (cnt == '0);
   assign head  = mem[rp];
endmodule : hrs_ioq
`default_nettype wire

/* File: rtl/hrs_resp.sv */
// response encoder and special-cycle handler for the host bus
`timescale 1ns/1ns
`default_nettype none
`include "hrs_consts.svh"
// What this block does
// - retry when resource unreachable now
// - retry only hub accesses, locked DRAM reads
// - defer only out-of-order capable transactions
// - no-data for writes, zero-length reads
// - implicit writeback on modified snoop hit
// - normal data for reads; 000 idle
// - special cycle: 01000 and xx001
// - first phase address ignored for special
// - type from second-phase byte field
// - nop completes with no effect
// - shutdown forwarded, retired after master abort
// - flush retired locally
// - halt forwarded, retired after master abort
// - sync retired locally
// - flush acknowledge retired locally
// - stop grant forwarded, retired after abort
// - smm ack with bit7 opens smm space
// - bit7 accesses go to smm space while it is open
// - smm ack never forwarded to hub
// - smm ack without bit7 closes space
// - in-order processing, four outstanding
module hrs_resp #(
   parameter int IOQ_DEPTH = `HRS_IOQ_DEPTH
) (
   input  wire logic        ref_clk,                   // host clock 25 MHz
   input  wire logic        resetn,                    // async reset, low
   input  wire logic        req_valid,                 // request phase strobe
   input  wire logic [4:0]  request_code_first_phase,  // first request code
   input  wire logic [4:0]  request_code_second_phase, // second request code
   input  wire logic [32:0] first_phase_address,       // first address phase
   input  wire logic [7:0]  second_phase_type_field,   // second phase type
   input  wire logic        smm_space_select_bit,      // second phase bit 7
   input  wire logic        is_read,                   // decoded: read
   input  wire logic        zero_len,                  // decoded: zero length
   input  wire logic        hub_target,                // decoded: to hub
   input  wire logic        gfx_target,                // decoded: to graphics
   input  wire logic        io_space,                  // decoded: i/o cycle
   input  wire logic        int_ack,                   // decoded: int ack
   input  wire logic        locked_dram_rd,            // decoded: locked DRAM read
   input  wire logic        busy,                      // resource unreachable now
   input  wire logic        defer_en,                  // deferral allowed
   input  wire logic        snoop_hitm,                // snoop hit modified
   input  wire logic        data_done,                 // read data ready / done
   input  wire logic        hub_master_abort,          // hub cycle ended by abort
   output logic             full,                      // ioq full, stall requests
   output logic [2:0]       response_status_code,      // response encoding
   output logic             resp_valid,                // response strobe
   output logic             hub_special_req,           // hub special cycle request
   output logic [1:0]       hub_special_kind,          // hub special kind
   output logic             system_management_mode,    // smm space open
   output logic             smm_access                 // last request hits smm space
);
   // queued word: special, type(8), bits smm bit7,read,zl,retry-able,deferrable
   localparam int QW = 14;
   logic          q_full, q_empty, q_pop;
   logic [QW-1:0] q_head, q_in;
   logic          special;

   // special cycle detect, address phase one not used
   assign special = (request_code_first_phase == `HRS_REQA_SPECIAL)
                 && (request_code_second_phase[2:0] == `HRS_REQB_SPECIAL);

   // can-defer: hub reads/io writes/int ack, gfx reads/io writes
   function automatic logic can_defer(input logic rd, input logic hub, input logic gfx,
                                      input logic io, input logic ia);
      can_defer = (hub && (rd || io || ia)) || (gfx && (rd || io));
   endfunction : can_defer

   always_comb begin
      q_in = {special, second_phase_type_field, smm_space_select_bit, is_read, zero_len,
              (hub_target || locked_dram_rd),
              can_defer(is_read, hub_target, gfx_target, io_space, int_ack)};
   end

   // in-order queue of four outstanding requests
   hrs_ioq #(.WIDTH(QW), .DEPTH(IOQ_DEPTH)) hrs_ioq_i (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .push      (req_valid),
      .push_data (q_in),
      .pop       (q_pop),
      .full      (q_full),
      .empty     (q_empty),
      .head      (q_head)
   );

   wire       h_spec  = q_head[13];
   wire [7:0] h_type  = q_head[12:5];
   wire       h_b7    = q_head[4];
   wire       h_rd    = q_head[3];
   wire       h_zl    = q_head[2];
   wire       h_retry = q_head[1];
   wire       h_defer = q_head[0];

   hrs_pkg::hrs_state_e state, next_state;
   logic [2:0] next_rs;
   logic       next_rv, next_hreq, next_smm, next_acc, next_full;
   logic [1:0] next_kind;

   // response selection per head of queue
   always_comb begin
      next_state = state;
      next_rs    = `HRS_RS_IDLE;
      next_rv    = 1'b0;
      next_hreq  = hub_special_req;
      next_kind  = hub_special_kind;
      next_smm   = system_management_mode;
      next_acc   = smm_access;
      next_full  = q_full;
      q_pop      = 1'b0;
      if (req_valid && !special) begin
         next_acc = system_management_mode && smm_space_select_bit;
      end
      unique case (state)
         hrs_pkg::HRS_IDLE: begin
            if (!q_empty) begin
               if (h_spec) begin
                  unique case (h_type)
                     `HRS_SC_SHUTDOWN: begin
                        next_hreq  = 1'b1;
                        next_kind  = hrs_pkg::HRS_HUB_SHUTDOWN;
                        next_state = hrs_pkg::HRS_HUB;
                     end
                     `HRS_SC_HALT: begin
                        next_hreq  = 1'b1;
                        next_kind  = hrs_pkg::HRS_HUB_HALT;
                        next_state = hrs_pkg::HRS_HUB;
                     end
                     `HRS_SC_STOP_ACK: begin
                        next_hreq  = 1'b1;
                        next_kind  = hrs_pkg::HRS_HUB_STOP;
                        next_state = hrs_pkg::HRS_HUB;
                     end
                     `HRS_SC_SMM_ACK: begin
                        next_smm   = h_b7;
                        next_state = hrs_pkg::HRS_RESP;
                     end
                     default: begin
                        // nop, flush, sync, flush ack and reserved: retire here
                        next_state = hrs_pkg::HRS_RESP;
                     end
                  endcase
               end else if (snoop_hitm) begin
                  next_rs    = `HRS_RS_IWB;
                  next_rv    = 1'b1;
                  q_pop      = 1'b1;
               end else if (busy && h_retry) begin
                  next_rs    = `HRS_RS_RETRY;
                  next_rv    = 1'b1;
                  q_pop      = 1'b1;
               end else if (busy && defer_en && h_defer) begin
                  next_rs    = `HRS_RS_DEFER;
                  next_rv    = 1'b1;
                  q_pop      = 1'b1;
               end else if (data_done) begin
                  next_rs    = (h_rd && !h_zl) ? `HRS_RS_NORMAL : `HRS_RS_NODATA;
                  next_rv    = 1'b1;
                  q_pop      = 1'b1;
               end
            end
         end
         hrs_pkg::HRS_HUB: begin
            if (hub_master_abort) begin
               next_hreq  = 1'b0;
               next_state = hrs_pkg::HRS_RESP;
            end
         end
         hrs_pkg::HRS_RESP: begin
            next_rs    = `HRS_RS_NODATA;
            next_rv    = 1'b1;
            q_pop      = 1'b1;
            next_state = hrs_pkg::HRS_IDLE;
         end
         default: next_state = hrs_pkg::HRS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state                  <= hrs_pkg::HRS_IDLE;
         response_status_code   <= `HRS_RS_IDLE;
         resp_valid             <= 1'b0;
         hub_special_req        <= 1'b0;
         hub_special_kind       <= 2'h0;
         system_management_mode <= 1'b0;
         smm_access             <= 1'b0;
         full                   <= 1'b0;
      end else begin
         state                  <= next_state;
         response_status_code   <= next_rs;
         resp_valid             <= next_rv;
         hub_special_req        <= next_hreq;
         hub_special_kind       <= next_kind;
         system_management_mode <= next_smm;
         smm_access             <= next_acc;
         full                   <= next_full;
      end
   end

   // response sequences
   sequence s_abort;
      hub_special_req && hub_master_abort;
   endsequence
   sequence s_retire;
      ##2 resp_valid && response_status_code == `HRS_RS_NODATA;
   endsequence

   a_no_bad_codes: assert property (@(posedge ref_clk) disable iff (!resetn)
      !(response_status_code inside {3'h3, 3'h4}))
      else $error("hard failure or reserved code driven");
   a_abort_retire: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_abort |-> s_retire)
      else $error("forwarded special not retired after abort");
   a_valid_code: assert property (@(posedge ref_clk) disable iff (!resetn)
      !resp_valid |-> response_status_code == `HRS_RS_IDLE)
      else $error("code without response strobe");
   a_hub_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
      hub_special_req && !hub_master_abort |=> hub_special_req)
      else $error("hub special dropped before abort");
   a_smm_stable: assert property (@(posedge ref_clk) disable iff (!resetn)
      $changed(system_management_mode) |-> $past(state) == hrs_pkg::HRS_IDLE)
      else $error("smm changed outside special decode");
   a_smm_access: assert property (@(posedge ref_clk) disable iff (!resetn)
      req_valid && !special |=> smm_access ==
         ($past(system_management_mode) && $past(smm_space_select_bit)))
      else $error("smm access flag not taken from open space and bit 7");
   a_no_fwd_smm: assert property (@(posedge ref_clk) disable iff (!resetn)
      $changed(system_management_mode) |-> !$rose(hub_special_req))
      else $error("smm ack forwarded to hub");
   a_iwb_hitm: assert property (@(posedge ref_clk) disable iff (!resetn)
      resp_valid && response_status_code == `HRS_RS_IWB |-> $past(snoop_hitm))
      else $error("implicit writeback without hit");
endmodule : hrs_resp
`default_nettype wire

/* File: verif/hrs_cpu_model.sv */
// processor agent model issuing host request phases
`timescale 1ns/1ns
`default_nettype none
module hrs_cpu_model (
   input  wire logic        ref_clk,   // host clock
   output logic             req_valid, // request strobe
   output logic [4:0]       code_a,    // first request code
   output logic [4:0]       code_b,    // second request code
   output logic [32:0]      addr,      // first address phase
   output logic [7:0]       type_f,    // second phase type
   output logic             bit7,      // smm select bit
   output logic [6:0]       dec        // decode flags
);
   logic [32:0] junk = 33'h0; // moving address pattern
   // quiet bus at time zero
   initial begin
      {req_valid, code_a, code_b, type_f, bit7, dec} = '0;
   end
   // address is junk that moves every cycle
   always @(posedge ref_clk) begin
      junk <= ~junk ^ 33'h1;
   end
   assign addr = junk;
   // drive one request phase, caller sits just after an edge
   task issue(input logic [4:0] a, input logic [4:0] b, input logic [7:0] t,
              input logic s, input logic [6:0] d);
      code_a = a;
      code_b = b;
      type_f = t;
      bit7 = s;
      dec = d;
      req_valid = 1'b1;
      @(posedge ref_clk);
      #1;
   endtask : issue
   // release: lines show the inverse of the last value
   task idle;
      req_valid = 1'b0;
      {code_a, code_b, type_f, bit7, dec} = ~{code_a, code_b, type_f, bit7, dec};
   endtask : idle
endmodule : hrs_cpu_model
`default_nettype wire

/* File: verif/hrs_resp_test.sv */
// self-checking bench for the host response block
`timescale 1ns/1ns
`default_nettype none
`include "hrs_consts.svh"
module hrs_resp_test;
   localparam logic [4:0] SPA = 5'h08; // special first code
   localparam logic [4:0] SPB = 5'h19; // special second code, xx001
   localparam logic [6:0] RD = 7'h40, ZL = 7'h20, HUB = 7'h10, GFX = 7'h08, IO = 7'h04;
   logic        ref_clk = 1'b0;          // host clock
   logic        resetn = 1'b0;           // reset, low
   logic        busy = 1'b0;             // resource busy
   logic        defer_en = 1'b0;         // deferral allowed
   logic        snoop_hitm = 1'b0;       // snoop hit modified
   logic        data_done = 1'b0;        // data ready
   logic        hub_master_abort = 1'b0; // hub abort
   logic        hub_seen = 1'b0;         // hub request seen
   logic        resp_seen = 1'b0;        // response seen
   logic        seen_clr = 1'b0;         // clears the seen flags
   int          fail_count = 0;          // mismatches
   int          check_count = 0;         // comparisons
   wire logic        req_valid, full, resp_valid, hub_special_req, smm_mode, smm_acc;
   wire logic [4:0]  code_a, code_b;
   wire logic [32:0] addr;
   wire logic [7:0]  type_f;
   wire logic        bit7;
   wire logic [6:0]  dec;
   wire logic [2:0]  rs;
   wire logic [1:0]  kind;
   // clock
   always #20 ref_clk = ~ref_clk;
   // flags of what the design showed, cleared at each new request issued by req
   always @(posedge ref_clk) begin
      if (seen_clr) begin
         hub_seen <= 1'b0;
         resp_seen <= 1'b0;
      end else begin
         if (hub_special_req === 1'b1) hub_seen <= 1'b1;
         if (resp_valid === 1'b1) resp_seen <= 1'b1;
      end
   end
   hrs_cpu_model hrs_cpu_model_i (.ref_clk(ref_clk), .req_valid(req_valid), .code_a(code_a),
      .code_b(code_b), .addr(addr), .type_f(type_f), .bit7(bit7), .dec(dec));
   hrs_resp hrs_resp_i (.ref_clk(ref_clk), .resetn(resetn), .req_valid(req_valid),
      .request_code_first_phase(code_a), .request_code_second_phase(code_b),
      .first_phase_address(addr), .second_phase_type_field(type_f),
      .smm_space_select_bit(bit7), .is_read(dec[6]), .zero_len(dec[5]),
      .hub_target(dec[4]), .gfx_target(dec[3]), .io_space(dec[2]), .int_ack(dec[1]),
      .locked_dram_rd(dec[0]), .busy(busy), .defer_en(defer_en), .snoop_hitm(snoop_hitm),
      .data_done(data_done), .hub_master_abort(hub_master_abort), .full(full),
      .response_status_code(rs), .resp_valid(resp_valid), .hub_special_req(hub_special_req),
      .hub_special_kind(kind), .system_management_mode(smm_mode), .smm_access(smm_acc));
   // compare and count
   task check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task close_out;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   task step(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         #1;
      end
   endtask : step
   task req(input logic [4:0] a, input logic [4:0] b, input logic [7:0] t,
            input logic s, input logic [6:0] d);
      seen_clr = 1'b1;
      hrs_cpu_model_i.issue(a, b, t, s, d);
      seen_clr = 1'b0;
      hrs_cpu_model_i.idle();
   endtask : req
   // wait a bounded time for the next response and judge its code
   task wait_resp(input logic [2:0] exp);
      int k;
      k = 0;
      while (resp_valid !== 1'b1 && k < 20) begin
         step(1);
         k++;
      end
      check({4'h0, resp_valid, rs}, {4'h0, 1'b1, exp});
      step(1);
   endtask : wait_resp
   task t_data;
      data_done = 1'b1;
      req(5'h06, 5'h00, 8'h00, 1'b0, RD);
      wait_resp(`HRS_RS_NORMAL);
      req(5'h07, 5'h00, 8'h00, 1'b0, 7'h00);
      wait_resp(`HRS_RS_NODATA);
      req(5'h06, 5'h00, 8'h00, 1'b0, RD | ZL);
      wait_resp(`HRS_RS_NODATA);
      snoop_hitm = 1'b1;
      req(5'h06, 5'h00, 8'h00, 1'b0, RD);
      wait_resp(`HRS_RS_IWB);
      snoop_hitm = 1'b0;
   endtask : t_data
   task t_busy;
      busy = 1'b1;
      req(5'h06, 5'h00, 8'h00, 1'b0, RD | HUB);
      wait_resp(`HRS_RS_RETRY);
      req(5'h06, 5'h00, 8'h00, 1'b0, RD | 7'h01);
      wait_resp(`HRS_RS_RETRY);
      defer_en = 1'b1;
      req(5'h10, 5'h00, 8'h00, 1'b0, RD | GFX | IO);
      wait_resp(`HRS_RS_DEFER);
      req(5'h05, 5'h00, 8'h00, 1'b0, 7'h00);
      wait_resp(`HRS_RS_NODATA);
      busy = 1'b0;
      defer_en = 1'b0;
   endtask : t_busy
   task t_local;
      logic [7:0] tl [6];
      tl = '{8'h00, 8'h02, 8'h04, 8'h05, 8'h08, 8'hff};
      foreach (tl[i]) begin
         req(SPA, SPB, tl[i], 1'b0, 7'h00);
         wait_resp(`HRS_RS_NODATA);
         check({7'h0, hub_seen}, 8'h00);
      end
   endtask : t_local
   task t_fwd;
      logic [7:0] tf [3];
      int k;
      tf = '{8'h01, 8'h03, 8'h06};
      foreach (tf[i]) begin
         req(SPA, SPB, tf[i], 1'b0, 7'h00);
         k = 0;
         while (hub_special_req !== 1'b1 && k < 10) begin
            step(1);
            k++;
         end
         check({6'h0, kind}, i[7:0]);
         step(5);
         check({7'h0, resp_seen}, 8'h00);
         hub_master_abort = 1'b1;
         step(1);
         hub_master_abort = 1'b0;
         wait_resp(`HRS_RS_NODATA);
         step(1);
         check({7'h0, hub_special_req}, 8'h00);
      end
   endtask : t_fwd
   task t_smm;
      req(SPA, 5'h00, `HRS_SC_SMM_ACK, 1'b1, RD | HUB | 7'h02);
      wait_resp(`HRS_RS_NORMAL);
      check({7'h0, smm_mode}, 8'h00);
      check({7'h0, smm_acc}, 8'h00);
      req(SPA, SPB, `HRS_SC_SMM_ACK, 1'b1, 7'h00);
      wait_resp(`HRS_RS_NODATA);
      check({6'h0, smm_mode, hub_seen}, 8'h02);
      req(5'h06, 5'h00, 8'h00, 1'b1, RD);
      wait_resp(`HRS_RS_NORMAL);
      check({7'h0, smm_acc}, 8'h01);
      req(SPA, SPB, `HRS_SC_SMM_ACK, 1'b0, 7'h00);
      wait_resp(`HRS_RS_NODATA);
      check({6'h0, smm_mode, hub_seen}, 8'h00);
      req(5'h06, 5'h00, 8'h00, 1'b1, RD);
      wait_resp(`HRS_RS_NORMAL);
      check({7'h0, smm_acc}, 8'h00);
   endtask : t_smm
   task t_order;
      data_done = 1'b0;
      hrs_cpu_model_i.issue(5'h07, 5'h00, 8'h00, 1'b0, 7'h00);
      hrs_cpu_model_i.issue(5'h06, 5'h00, 8'h00, 1'b0, RD);
      hrs_cpu_model_i.issue(5'h07, 5'h00, 8'h00, 1'b0, 7'h00);
      hrs_cpu_model_i.issue(5'h06, 5'h00, 8'h00, 1'b0, RD);
      hrs_cpu_model_i.idle();
      step(1);
      check({7'h0, full}, 8'h01);
      data_done = 1'b1;
      wait_resp(`HRS_RS_NODATA);
      wait_resp(`HRS_RS_NORMAL);
      wait_resp(`HRS_RS_NODATA);
      wait_resp(`HRS_RS_NORMAL);
   endtask : t_order
   // main sequence
   initial begin
      repeat (5) @(posedge ref_clk);
      #1;
      resetn = 1'b1;
      step(1);
      t_data();
      t_busy();
      t_local();
      t_fwd();
      t_smm();
      t_order();
      close_out();
   end
   // watchdog
   initial begin
      #400000;
      fail_count++;
      close_out();
   end
endmodule : hrs_resp_test
`default_nettype wire
